// ### rtl/mmd_pkg.sv
// Package for the memory map select decoder: map constants and types
package mmd_pkg;

   localparam int unsigned ADDR_W = 16;
   localparam int unsigned PAGE_W = 6;
   localparam int unsigned DATA_W = 16;

   // Program page window and unpaged upper block
   localparam logic [15:0] WIN_BASE = 16'h8000;
   localparam logic [15:0] WIN_LAST = 16'hbfff;
   localparam logic [15:0] TOP_BASE = 16'hc000;
   localparam logic [15:0] TOP_LAST = 16'hffff;

   // Internal page thresholds per partition setting
   localparam logic [5:0] PART_THR_128K = 6'h38;
   localparam logic [5:0] PART_THR_256K = 6'h30;
   localparam logic [5:0] PART_THR_512K = 6'h20;

   localparam logic [5:0] PAGE_RESET = 6'h00;

   // Register offsets inside the register block (low bits of address)
   localparam logic [9:0] OFS_PORTA_DAT = 10'h000;
   localparam logic [9:0] OFS_PORTB_DAT = 10'h001;
   localparam logic [9:0] OFS_PORTA_DIR = 10'h002;
   localparam logic [9:0] OFS_PORTB_DIR = 10'h003;
   localparam logic [9:0] OFS_PORTE_DAT = 10'h008;
   localparam logic [9:0] OFS_PORTE_DIR = 10'h009;
   localparam logic [9:0] OFS_EXP_LAST  = 10'h00f;
   localparam logic [9:0] OFS_PORTK_DAT = 10'h032;
   localparam logic [9:0] OFS_PORTK_DIR = 10'h033;
   localparam logic [9:0] OFS_PAGE_REG  = 10'h030;
   localparam int unsigned REG_SPAN_W   = 10;

   typedef enum logic [1:0] {
      PART_128K,
      PART_256K,
      PART_512K,
      PART_1M
   } mmd_part_t;

   typedef enum logic [2:0] {
      MODE_SINGLE,
      MODE_NORMAL_EXP,
      MODE_SPECIAL_PERIPH,
      MODE_EMUL_EXP,
      MODE_SPECIAL_SINGLE
   } mmd_mode_t;

   typedef enum logic [2:0] {
      SEL_NONE,
      SEL_DEBUG,
      SEL_REGS,
      SEL_RAM,
      SEL_EEPROM,
      SEL_FLASH,
      SEL_EXTERNAL
   } mmd_sel_t;

   typedef enum logic [1:0] {
      PCMD_NONE,
      PCMD_CALL,
      PCMD_RETURN
   } mmd_pcmd_t;

endpackage

// ### rtl/mmd_page_if.sv
// Interface carrying page register state and update requests
`timescale 1ns/1ps
interface mmd_page_if;
   import mmd_pkg::*;
   logic [PAGE_W-1:0] page;
   logic              wr_en;
   logic [PAGE_W-1:0] wr_data;
   mmd_pcmd_t         cmd;
   logic [PAGE_W-1:0] cmd_page;
   logic              busy;
   logic [PAGE_W-1:0] saved_page;
   modport keeper (output page, busy, saved_page,
                   input wr_en, wr_data, cmd, cmd_page);
   modport user   (input page, busy, saved_page,
                   output wr_en, wr_data, cmd, cmd_page);
endinterface

// ### rtl/mmd_page_reg.sv
// Program page register with ordinary and paged call/return update paths
`timescale 1ns/1ps
module mmd_page_reg (
   input  wire logic ref_clk,
   input  wire logic rst_n,
   mmd_page_if.keeper pg
);
   import mmd_pkg::*;

   logic [PAGE_W-1:0] page_q;
   logic [PAGE_W-1:0] temp_q;

   assign pg.page       = page_q;
   assign pg.saved_page = temp_q;
   assign pg.busy       = 1'b0;

   // Call: old value into temp and new value loaded in the same edge
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         page_q <= PAGE_RESET;
      end else if (pg.cmd != PCMD_NONE) begin
         page_q <= pg.cmd_page; // see (R15) see (R22)
      end else if (pg.wr_en) begin
         page_q <= pg.wr_data; // see (R22)
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         temp_q <= PAGE_RESET;
      end else if (pg.cmd == PCMD_CALL) begin
         temp_q <= page_q; // see (R16)
      end
   end

   chk_write_one_cycle: assert property (@(posedge ref_clk) disable iff (!rst_n)
      pg.wr_en && pg.cmd == PCMD_NONE |=> page_q == $past(pg.wr_data))
      else $error("page write not applied next cycle"); // see (R22)
   chk_call_saves_old: assert property (@(posedge ref_clk) disable iff (!rst_n)
      pg.cmd == PCMD_CALL |=> temp_q == $past(page_q)
         && page_q == $past(pg.cmd_page))
      else $error("call did not save old page"); // see (R16)
endmodule

// ### rtl/mmd_seq.sv
// Paged call/return sequencer: drives page updates and stack steps
`timescale 1ns/1ps
module mmd_seq (
   input  wire logic                       ref_clk,
   input  wire logic                       rst_n,
   input  wire logic                       call_start,
   input  wire logic                       call_indirect,
   input  wire logic [mmd_pkg::PAGE_W-1:0] imm_page,
   input  wire logic                       ret_start,
   input  wire logic [15:0]                mem_data,
   input  wire logic [15:0]                ret_addr,
   output logic                            stack_push,
   output logic                            stack_pull,
   output logic [15:0]                     stack_wdata,
   output logic                            ptr_read,
   output logic                            pc_load,
   output logic [15:0]                     pc_value,
   output logic                            queue_refill,
   output logic                            seq_active,
   mmd_page_if.user                        pg
);
   import mmd_pkg::*;

   typedef enum logic [3:0] {
      S_IDLE, S_CALL_PTR_PG, S_CALL_PTR_AD, S_CALL_LOAD, S_CALL_PUSH_RA,
      S_CALL_PUSH_PG, S_CALL_FETCH, S_RET_PULL_PG, S_RET_PULL_RA,
      S_RET_WRITE, S_RET_REFILL
   } mmd_seq_state_t;

   mmd_seq_state_t    state_q;
   logic [PAGE_W-1:0] newpg_q;
   logic [15:0]       target_q;
   logic [PAGE_W-1:0] oldpg_q;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_q <= S_IDLE;
      end else begin
         case (state_q)
            S_IDLE: begin
               if (call_start && call_indirect) begin
                  state_q <= S_CALL_PTR_PG; // see (R17)
               end else if (call_start) begin
                  state_q <= S_CALL_LOAD;
               end else if (ret_start) begin
                  state_q <= S_RET_PULL_PG;
               end
            end
            S_CALL_PTR_PG:  state_q <= S_CALL_PTR_AD;
            S_CALL_PTR_AD:  state_q <= S_CALL_LOAD;
            S_CALL_LOAD:    state_q <= S_CALL_PUSH_RA; // see (R16)
            S_CALL_PUSH_RA: state_q <= S_CALL_PUSH_PG;
            S_CALL_PUSH_PG: state_q <= S_CALL_FETCH;
            S_CALL_FETCH:   state_q <= S_IDLE;
            S_RET_PULL_PG:  state_q <= S_RET_PULL_RA; // see (R18)
            S_RET_PULL_RA:  state_q <= S_RET_WRITE;
            S_RET_WRITE:    state_q <= S_RET_REFILL;
            S_RET_REFILL:   state_q <= S_IDLE;
            default:        state_q <= S_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         newpg_q  <= PAGE_RESET;
         target_q <= 16'h0000;
         oldpg_q  <= PAGE_RESET;
      end else begin
         if (state_q == S_IDLE && call_start) begin
            newpg_q  <= imm_page; // see (R17)
            target_q <= mem_data;
         end
         if (state_q == S_CALL_PTR_PG) begin
            newpg_q <= mem_data[PAGE_W-1:0]; // see (R17)
         end
         if (state_q == S_CALL_PTR_AD) begin
            target_q <= mem_data;
         end
         if (state_q == S_RET_PULL_PG) begin
            oldpg_q <= mem_data[PAGE_W-1:0];
         end
         if (state_q == S_RET_PULL_RA) begin
            target_q <= mem_data;
         end
      end
   end

   always_comb begin
      pg.cmd       = PCMD_NONE;
      pg.cmd_page  = newpg_q;
      stack_push   = 1'b0;
      stack_pull   = 1'b0;
      stack_wdata  = 16'h0000;
      ptr_read     = 1'b0;
      pc_load      = 1'b0;
      pc_value     = target_q;
      queue_refill = 1'b0;
      case (state_q)
         S_CALL_PTR_PG, S_CALL_PTR_AD: ptr_read = 1'b1;
         S_CALL_LOAD: pg.cmd = PCMD_CALL; // see (R16)
         S_CALL_PUSH_RA: begin
            stack_push  = 1'b1;
            stack_wdata = ret_addr;
         end
         S_CALL_PUSH_PG: begin
            stack_push  = 1'b1;
            stack_wdata = {{(16-PAGE_W){1'b0}}, pg.saved_page};
         end
         S_CALL_FETCH: begin
            pc_load      = 1'b1;
            queue_refill = 1'b1;
         end
         S_RET_PULL_PG: stack_pull = 1'b1;
         S_RET_PULL_RA: stack_pull = 1'b1;
         S_RET_WRITE: begin
            pc_load     = 1'b1;
            pg.cmd      = PCMD_RETURN; // see (R18)
            pg.cmd_page = oldpg_q;
         end
         S_RET_REFILL: queue_refill = 1'b1;
         default: ;
      endcase
   end

   // Interrupts are held off for the whole sequence
   assign seq_active = (state_q != S_IDLE); // see (R19)

   chk_ret_order: assert property (@(posedge ref_clk) disable iff (!rst_n)
      state_q == S_RET_PULL_PG |=> stack_pull ##1 pc_load
         && pg.cmd == PCMD_RETURN ##1 queue_refill)
      else $error("return sequence order broken"); // see (R18)
   chk_seq_atomic: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(seq_active) |-> seq_active[*4])
      else $error("sequence interrupted early"); // see (R19)
endmodule

// ### rtl/mmd_decoder.sv
// Memory map select decoder top: priority selects, chip selects, paging
//
// Notes on behaviour
// (R1) One select at a time, fixed priority order
// (R2) Overlaps select only the higher priority block
// (R3) Expanded: unclaimed space and ports A/B external
// (R4) Port E emulation enable removes port E registers
// (R5) Peripheral mode removes first 16 expansion registers
// (R6) Emulation with port K enable removes port K registers
// (R7) Port K bit 7 is emulation chip select
// (R8) Port K bit 6 is external chip select
// (R9) No external select for holes or removed registers
// (R10) Enable clear: port K bits 7,6 general purpose
// (R11) Page index maps 16K block into window
// (R12) Partition switches set on-chip paged size
// (R13) Page at or above threshold is internal
// (R14) Upper block 0xc000-0xffff always unpaged
// (R15) Page register written by bus or call/return
// (R16) Call saves, loads, pushes address then page
// (R17) Call page immediate, or via pointer indirect
// (R18) Return pulls page, address, writes page, refills
// (R19) Call and return sequences are uninterruptible
// (R20) Cross-page subroutines use call and return only
// (R21) Mux core data onto CPU read bus, bytes swapped when swap_bytes is set
// (R22) Bus page write effective one cycle later
// (R23) Selects combinational on current address and state
`timescale 1ns/1ps
module mmd_decoder (
   input  wire logic               ref_clk,
   input  wire logic               rst_n,
   input  wire logic [15:0]        cpu_addr,
   input  wire logic               cpu_write,
   input  wire logic               cpu_valid,
   input  wire logic [7:0]         cpu_wdata,
   input  wire mmd_pkg::mmd_mode_t op_mode,
   input  wire logic               port_e_emulation_enable,
   input  wire logic               port_k_emulation_enable,
   input  wire logic [1:0]         partition_switches,
   input  wire logic               debug_active,
   input  wire logic [15:0]        debug_base,
   input  wire logic [15:0]        reg_base,
   input  wire logic [15:0]        ram_base,
   input  wire logic [15:0]        ram_size,
   input  wire logic [15:0]        eeprom_base,
   input  wire logic [15:0]        eeprom_size,
   input  wire logic [15:0]        flash_base,
   input  wire logic               reg_implemented,
   input  wire logic               swap_bytes,
   input  wire logic [15:0]        debug_rdata,
   input  wire logic [15:0]        reg_rdata,
   input  wire logic [15:0]        ram_rdata,
   input  wire logic [15:0]        eeprom_rdata,
   input  wire logic [15:0]        flash_rdata,
   input  wire logic [15:0]        ext_rdata,
   input  wire logic [1:0]         port_k_gpio_out,
   input  wire logic [1:0]         port_k_gpio_oe,
   input  wire logic               call_start,
   input  wire logic               call_indirect,
   input  wire logic [5:0]         call_imm_page,
   input  wire logic               ret_start,
   input  wire logic [15:0]        ret_addr,
   output mmd_pkg::mmd_sel_t       block_sel,
   output logic                    window_access,
   output logic                    window_internal,
   output logic [5:0]              page_index_bits,
   output logic [19:0]             flat_addr,
   output logic [1:0]              port_k_hi_out,
   output logic [1:0]              port_k_hi_oe,
   output logic [15:0]             cpu_rdata,
   output logic                    stack_push,
   output logic                    stack_pull,
   output logic [15:0]             stack_wdata,
   output logic                    ptr_read,
   output logic                    pc_load,
   output logic [15:0]             pc_value,
   output logic                    queue_refill,
   output logic                    irq_inhibit
);
   import mmd_pkg::*;

   mmd_page_if pg ();

   mmd_page_reg u_page (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .pg      (pg)
   );

   logic bus_page_wr;
   logic cpu_wr_path;
   logic seq_wr_en;
   logic [5:0] seq_wr_data;

   mmd_seq u_seq (
      .ref_clk       (ref_clk),
      .rst_n         (rst_n),
      .call_start    (call_start),
      .call_indirect (call_indirect),
      .imm_page      (call_imm_page),
      .ret_start     (ret_start),
      .mem_data      (cpu_rdata),
      .ret_addr      (ret_addr),
      .stack_push    (stack_push),
      .stack_pull    (stack_pull),
      .stack_wdata   (stack_wdata),
      .ptr_read      (ptr_read),
      .pc_load       (pc_load),
      .pc_value      (pc_value),
      .queue_refill  (queue_refill),
      .seq_active    (irq_inhibit),
      .pg            (pg)
   );

   function automatic logic in_range(input logic [15:0] a,
                                     input logic [15:0] base,
                                     input logic [15:0] size);
      logic [16:0] off;
      off = {1'b0, a} - {1'b0, base};
      return (a >= base) && (off < {1'b0, size});
   endfunction

   function automatic logic is_expanded(input mmd_mode_t m);
      return m == MODE_NORMAL_EXP || m == MODE_EMUL_EXP
          || m == MODE_SPECIAL_PERIPH;
   endfunction

   logic        expanded;
   logic        emul;
   logic [9:0]  reg_ofs;
   logic        reg_hit;
   logic        reg_removed;
   logic        hit_debug;
   logic        hit_regs;
   logic        hit_ram;
   logic        hit_eeprom;
   logic        hit_flash;
   logic        top_block;
   logic [5:0]  part_thr;
   logic        emul_cs;
   logic        ext_cs;
   logic [15:0] raw_rdata;

   assign expanded = is_expanded(op_mode);
   assign emul     = (op_mode == MODE_EMUL_EXP);
   assign reg_ofs  = cpu_addr[9:0] - reg_base[9:0];
   assign reg_hit  = in_range(cpu_addr, reg_base, 16'h0400);

   // Registers handed to the external bus in the current mode
   always_comb begin
      reg_removed = 1'b0;
      if (expanded && reg_ofs <= OFS_PORTB_DIR) begin
         reg_removed = 1'b1; // see (R3)
      end
      if (expanded && port_e_emulation_enable
          && (reg_ofs == OFS_PORTE_DAT || reg_ofs == OFS_PORTE_DIR)) begin
         reg_removed = 1'b1; // see (R4)
      end
      if (op_mode == MODE_SPECIAL_PERIPH && reg_ofs <= OFS_EXP_LAST) begin
         reg_removed = 1'b1; // see (R5)
      end
      if (emul && port_k_emulation_enable
          && (reg_ofs == OFS_PORTK_DAT || reg_ofs == OFS_PORTK_DIR)) begin
         reg_removed = 1'b1; // see (R6)
      end
   end

   assign hit_debug  = debug_active && in_range(cpu_addr, debug_base,
                                                16'h0100);
   assign hit_regs   = reg_hit && !reg_removed;
   assign hit_ram    = in_range(cpu_addr, ram_base, ram_size);
   assign hit_eeprom = in_range(cpu_addr, eeprom_base, eeprom_size);
   assign top_block  = cpu_addr >= TOP_BASE; // see (R14)
   assign window_access = cpu_addr >= WIN_BASE && cpu_addr <= WIN_LAST;

   always_comb begin
      case (mmd_part_t'(partition_switches))
         PART_128K: part_thr = PART_THR_128K; // see (R12)
         PART_256K: part_thr = PART_THR_256K;
         PART_512K: part_thr = PART_THR_512K;
         default:   part_thr = 6'h00;
      endcase
   end

   assign page_index_bits = pg.page;
   assign window_internal = pg.page >= part_thr; // see (R13)
   assign hit_flash = top_block
                   || (cpu_addr >= flash_base && cpu_addr < WIN_BASE)
                   || (window_access && window_internal);

   // Flat 20-bit address: window uses the page, others fixed pages
   always_comb begin
      if (window_access) begin
         flat_addr = {pg.page, cpu_addr[13:0]}; // see (R11)
      end else begin
         flat_addr = {4'hf, cpu_addr};
      end
   end

   // Priority chain yields a single select; lower hits are hidden
   always_comb begin
      if (!cpu_valid) begin
         block_sel = SEL_NONE;
      end else if (hit_debug) begin
         block_sel = SEL_DEBUG; // see (R1) see (R23)
      end else if (hit_regs) begin
         block_sel = SEL_REGS; // see (R2)
      end else if (hit_ram) begin
         block_sel = SEL_RAM;
      end else if (hit_eeprom) begin
         block_sel = SEL_EEPROM;
      end else if (hit_flash) begin
         block_sel = SEL_FLASH;
      end else if (expanded) begin
         block_sel = SEL_EXTERNAL; // see (R3)
      end else begin
         block_sel = SEL_NONE;
      end
   end

   // Holes in register space never reach the external bus
   always_comb begin
      emul_cs = cpu_valid && emul && block_sel == SEL_FLASH; // see (R7)
      ext_cs  = cpu_valid && !emul_cs && expanded
             && block_sel == SEL_EXTERNAL
             && !(reg_hit && (reg_removed || !reg_implemented)); // see (R9)
   end

   always_comb begin
      if (port_k_emulation_enable) begin
         port_k_hi_out = {!emul_cs, !ext_cs}; // see (R7) see (R8)
         port_k_hi_oe  = 2'b11;
      end else begin
         port_k_hi_out = port_k_gpio_out; // see (R10)
         port_k_hi_oe  = port_k_gpio_oe;
      end
   end

   // Read data mux and byte swap
   always_comb begin
      case (block_sel)
         SEL_DEBUG:    raw_rdata = debug_rdata; // see (R21)
         SEL_REGS:     raw_rdata = reg_rdata;
         SEL_RAM:      raw_rdata = ram_rdata;
         SEL_EEPROM:   raw_rdata = eeprom_rdata;
         SEL_FLASH:    raw_rdata = flash_rdata;
         SEL_EXTERNAL: raw_rdata = ext_rdata;
         default:      raw_rdata = 16'h0000;
      endcase
      cpu_rdata = swap_bytes ? {raw_rdata[7:0], raw_rdata[15:8]}
                             : raw_rdata;
   end

   // Ordinary bus write to the page register
   assign cpu_wr_path = cpu_valid && cpu_write && hit_regs
                     && reg_ofs == OFS_PAGE_REG;
   assign bus_page_wr = cpu_wr_path && !irq_inhibit;
   assign seq_wr_en   = bus_page_wr; // see (R15)
   assign seq_wr_data = cpu_wdata[5:0];

   always_comb begin
      pg.wr_en   = seq_wr_en;
      pg.wr_data = seq_wr_data;
   end

   chk_hidden_regs: assert property (@(posedge ref_clk) disable iff (!rst_n)
      cpu_valid && hit_regs && !hit_debug |-> block_sel == SEL_REGS)
      else $error("register select lost priority"); // see (R2)
   chk_top_unpaged: assert property (@(posedge ref_clk) disable iff (!rst_n)
      top_block |-> flat_addr[19:16] == 4'hf)
      else $error("upper block was paged"); // see (R14)
   chk_cs_exclusive: assert property (@(posedge ref_clk) disable iff (!rst_n)
      port_k_emulation_enable |-> !(port_k_hi_out == 2'b00))
      else $error("both chip selects active"); // see (R8)
   chk_hole_no_xcs: assert property (@(posedge ref_clk) disable iff (!rst_n)
      port_k_emulation_enable && reg_hit && reg_removed
         |-> port_k_hi_out[0])
      else $error("external select on removed register"); // see (R9)
   chk_part_thr: assert property (@(posedge ref_clk) disable iff (!rst_n)
      partition_switches == 2'b00 && pg.page == 6'h37 |-> !window_internal)
      else $error("partition threshold wrong"); // see (R13)
endmodule

// ### tb/mmd_far_model.sv
// Far side model: source read data and a small stack
`timescale 1ns/1ps
module mmd_far_model (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic [15:0] cpu_addr,
   input  wire logic        stack_push,
   input  wire logic        stack_pull,
   input  wire logic [15:0] stack_wdata,
   output logic [15:0]      debug_rdata,
   output logic [15:0]      reg_rdata,
   output logic [15:0]      ram_rdata,
   output logic [15:0]      eeprom_rdata,
   output logic [15:0]      flash_rdata,
   output logic [15:0]      ext_rdata
);
   logic [15:0] stk_q [8];
   logic [2:0]  sp_q;
   assign debug_rdata  = {4'h1, cpu_addr[11:0]};
   assign reg_rdata    = {4'h2, cpu_addr[11:0]};
   assign eeprom_rdata = {4'h4, cpu_addr[11:0]};
   assign flash_rdata  = {4'h5, cpu_addr[11:0]};
   assign ext_rdata    = {4'h6, cpu_addr[11:0]};
   assign ram_rdata = (sp_q != 3'h0) ? stk_q[sp_q - 3'h1]
                                     : {4'h3, cpu_addr[11:0]};
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         sp_q <= 3'h0;
      end else if (stack_push) begin
         stk_q[sp_q] <= stack_wdata;
         sp_q <= sp_q + 3'h1;
      end else if (stack_pull) begin
         sp_q <= sp_q - 3'h1;
      end
   end
endmodule

// ### tb/testbench.sv
// Self-checking bench for the memory map select decoder
`timescale 1ns/1ps
module testbench;
   import mmd_pkg::*;
   logic ref_clk, rst_n = 0, cpu_write = 0, cpu_valid = 1, call_indirect = 0;
   logic debug_active = 0, swap_bytes = 0, reg_implemented = 1;
   logic port_e_emulation_enable = 0, port_k_emulation_enable = 0;
   logic call_start = 0, ret_start = 0, window_access, window_internal;
   logic stack_push, stack_pull, ptr_read, pc_load, queue_refill, irq_inhibit;
   logic [1:0] partition_switches = 0, port_k_gpio_out = 0, port_k_gpio_oe = 0;
   logic [1:0] port_k_hi_out, port_k_hi_oe;
   logic [5:0] call_imm_page = 0, page_index_bits, pg = 0;
   logic [7:0] cpu_wdata = 0;
   logic [15:0] cpu_addr = 16'h0400, ret_addr = 0, stack_wdata, pc_value;
   logic [15:0] debug_base = 16'hff00, reg_base = 0, ram_base = 0;
   logic [15:0] ram_size = 16'h2000, eeprom_base = 16'h2000;
   logic [15:0] eeprom_size = 16'h1000, flash_base = 16'h4000, cpu_rdata;
   logic [15:0] debug_rdata, reg_rdata, ram_rdata, eeprom_rdata;
   logic [15:0] flash_rdata, ext_rdata;
   logic [19:0] flat_addr;
   logic [5:0] pl [8] = '{6'h00, 6'h1f, 6'h20, 6'h2f, 6'h30, 6'h37, 6'h38, 6'h3f};
   logic [9:0] ol [11] = '{0, 1, 2, 3, 8, 9, 10'h00a, 10'h00f, 10'h010,
                           10'h032, 10'h033};
   logic [15:0] cl [8] = '{0, 16'h1fff, 16'h3fff, 16'h4000, 16'h7fff,
                           16'hbfff, 16'hc000, 16'hffff};
   mmd_mode_t ml [3] = '{MODE_NORMAL_EXP, MODE_EMUL_EXP, MODE_SPECIAL_PERIPH};
   mmd_mode_t op_mode = MODE_NORMAL_EXP;
   mmd_sel_t  block_sel;
   int fail_count = 0, n_compared = 0;

   mmd_decoder   u_mmd_decoder (.*);
   mmd_far_model u_mmd_far_model (.*);

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   task automatic chk(input string nm, input logic [23:0] e, g);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   function automatic logic win_int();
      case (partition_switches)
         2'b00: return pg >= PART_THR_128K;
         2'b01: return pg >= PART_THR_256K;
         2'b10: return pg >= PART_THR_512K;
         default: return 1'b1;
      endcase
   endfunction

   function automatic mmd_sel_t esel(input logic [15:0] a, output logic rm);
      logic [9:0] o;
      logic ex;
      o = a[9:0];
      ex = op_mode inside {MODE_NORMAL_EXP, MODE_EMUL_EXP};
      rm = a < 16'h0400 && (ex && o < 10'h004 || ex && port_e_emulation_enable
           && o inside {OFS_PORTE_DAT, OFS_PORTE_DIR}
           || op_mode == MODE_SPECIAL_PERIPH && o <= OFS_EXP_LAST
           || op_mode == MODE_EMUL_EXP && port_k_emulation_enable
           && o inside {OFS_PORTK_DAT, OFS_PORTK_DIR});
      if (debug_active && a >= debug_base && a - debug_base < 16'h0100)
         return SEL_DEBUG;
      if (a < 16'h0400) return SEL_REGS;
      if (a < ram_size) return SEL_RAM;
      if (a >= eeprom_base && a < eeprom_base + eeprom_size) return SEL_EEPROM;
      if (a[14] || a[15:14] == 2'b10 && win_int()) return SEL_FLASH;
      return SEL_EXTERNAL;
   endfunction

   task automatic probe(input logic [15:0] a);
      logic rm, hole, ec, xc;
      mmd_sel_t s;
      logic [15:0] d;
      @(posedge ref_clk);
      cpu_addr <= a;
      @(negedge ref_clk);
      s = esel(a, rm);
      hole = a < 16'h0400 && !reg_implemented && s == SEL_REGS;
      d = {4'(s), a[11:0]};
      if (swap_bytes) d = {d[7:0], d[15:8]};
      ec = !(op_mode == MODE_EMUL_EXP && s == SEL_FLASH);
      xc = hole || !(ec && s == SEL_EXTERNAL);
      if (rm) chk("not_regs", 1, block_sel != SEL_REGS);
      else if (!hole) chk("sel", s, block_sel);
      if (!rm && !hole) chk("rdata", d, cpu_rdata);
      if (port_k_emulation_enable)
         chk("cs_n", {ec, xc, 2'b11}, {port_k_hi_out, port_k_hi_oe});
      else
         chk("gpio", {port_k_gpio_out, port_k_gpio_oe}, {port_k_hi_out, port_k_hi_oe});
      chk("win", a[15:14] == 2'b10, window_access);
      if (a[15:14] == 2'b10)
         chk("flat", {win_int(), pg, a[13:0]}, {window_internal, flat_addr});
   endtask

   task automatic wpage(input logic [5:0] p);
      @(posedge ref_clk);
      {cpu_addr, cpu_wdata, cpu_write, reg_implemented} <= {16'h0030, 2'b00, p, 2'b11};
      @(negedge ref_clk);
      chk("page_old", pg, page_index_bits);
      @(posedge ref_clk);
      cpu_write <= 1'b0;
      @(negedge ref_clk);
      pg = p;
      chk("page", p, page_index_bits);
   endtask

   task automatic run_seq(input logic [5:0] np, input logic [15:0] ra);
      @(posedge ref_clk);
      {call_start, call_imm_page, ret_addr} <= {1'b1, np, ra};
      @(posedge ref_clk);
      {call_start, cpu_addr, cpu_wdata, cpu_write, ret_start} <= {17'h00030, 8'h15, 2'b11};
      @(negedge ref_clk);
      chk("call_pg", {1'b1, pg}, {irq_inhibit, page_index_bits});
      @(posedge ref_clk);
      {cpu_write, ret_start} <= 2'b00;
      @(negedge ref_clk);
      chk("push_ra", {1'b1, ra, np}, {stack_push, stack_wdata, page_index_bits});
      @(negedge ref_clk);
      chk("push_pg", {1'b1, 10'h000, pg}, {stack_push, stack_wdata});
      @(negedge ref_clk);
      chk("fetch", {2'b11, np}, {pc_load, queue_refill, page_index_bits});
      @(posedge ref_clk);
      {cpu_addr, ret_start} <= {16'h1000, 1'b1};
      @(posedge ref_clk);
      ret_start <= 1'b0;
      @(negedge ref_clk);
      chk("pull_pg", 1, stack_pull);
      @(negedge ref_clk);
      chk("pull_ra", 1, stack_pull);
      @(negedge ref_clk);
      chk("pc", {1'b1, ra}, {pc_load, pc_value});
      @(negedge ref_clk);
      chk("refill", {1'b1, pg}, {queue_refill, page_index_bits});
   endtask

   initial begin
      void'($urandom(97273));
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(negedge ref_clk);
      chk("page_rst", PAGE_RESET, page_index_bits);
      foreach (ml[m]) begin
         for (int k = 0; k < 4; k++) begin
            @(posedge ref_clk);
            op_mode <= ml[m];
            {port_k_emulation_enable, port_e_emulation_enable} <= 2'(k);
            foreach (ol[i]) probe({6'h00, ol[i]});
         end
      end
      op_mode <= MODE_NORMAL_EXP;
      for (int s = 0; s < 4; s++) begin
         foreach (pl[i]) begin
            @(posedge ref_clk);
            partition_switches <= 2'(s);
            wpage(pl[i]);
            probe({2'b10, 14'($urandom)});
            probe({2'b11, 14'($urandom)});
         end
      end
      run_seq(6'h2a, 16'h9abc);
      repeat (300) begin
         @(posedge ref_clk);
         op_mode <= $urandom_range(1) ? MODE_EMUL_EXP : MODE_NORMAL_EXP;
         {port_k_emulation_enable, port_e_emulation_enable} <= 2'($urandom);
         {debug_active, swap_bytes, port_k_gpio_out} <= 4'($urandom);
         {port_k_gpio_oe, partition_switches} <= 4'($urandom);
         reg_implemented <= $urandom_range(7) != 0;
         debug_base <= $urandom_range(1) ? 16'hff00 : 16'hc000;
         eeprom_size <= $urandom_range(1) ? 16'h1000 : 16'h0800;
         ram_size <= $urandom_range(1) ? 16'h2000 : 16'h1000;
         if ($urandom_range(3) == 0) wpage(6'($urandom));
         probe(16'($urandom));
      end
      foreach (cl[i]) probe(cl[i]);
      print_verdict();
   end

   initial begin
      repeat (20000) @(posedge ref_clk);
      fail_count++;
      print_verdict();
   end
endmodule
